// *** core/aclrm_top.sv ***
// per-port acl evaluation, table, counters and wishbone registers
// Operation
// - rule_mode disables, or picks layer 2/3/4
// - algorithm 0: down-counter, event on timeout
// - algorithm 1: count matches, event at terminal
// - 11-bit count; time_unit_sel picks us or ms
// - layer 3 select: masked single, unmasked pair
// - address picked by direction; pair takes w2 as destination
// - mask bit 0 compares, 1 ignores
// - src_dst_select 0 destination, 1 source
// - match_polarity 0 inequality, 1 equality true
// - layer 4: protocol, tcp, udp, sequence
// - bounds 16 bit; joined 32 bit sequence
// - port compare: off, either, inside, outside
// - protocol byte against ip_next_header_value
// - tcp flags compared except ignored bits
// - priority override by mode and ranking_value
// - remark replaces pcp with remark_level
// - forward map merge: keep, or, and, replace
// - map bit 0 is port 1
// - sixteen entries, independent fields
// - count mode joins match and action fields
// - layer 2: count, mac, ethertype, both
// - group bits and selected match entries
// - lowest entry_rank among matches wins
module aclrm_top
  import aclrm_pkg::*;
#(
  parameter int US_PER_MS = MS_PER_US
) (
  input  wire logic                   SYS_CLK,
  input  wire logic                   ARST_N,
  input  wire logic                   WB_CYC_I,
  input  wire logic                   WB_STB_I,
  input  wire logic                   WB_WE_I,
  input  wire logic [7:0]             WB_ADR_I,
  input  wire logic [3:0]             WB_SEL_I,
  input  wire logic [31:0]            WB_DAT_I,
  output logic      [31:0]            WB_DAT_O,
  output logic                        WB_ACK_O,
  input  wire logic                   PKT_VALID,
  input  wire aclrm_hdr_s             PKT_HDR,
  output aclrm_res_s                  RES,
  output logic                        RES_VALID,
  output logic                        EVENT_OUT
);

  // ----------------------------------------
  // table entry words
  // ----------------------------------------
  // w0: [1:0] rule_mode [3:2] compare_select [4] src_dst_select [5] match_polarity
  //     [7:6] l4_port_compare_mode [15:8] ip_next_header_value [16] flag_match_on
  //     [24:17] flag_ignore_bits
  // w1: [31:0] ip address / mac[31:0] / bounds {upper,lower} / tcp flag in [7:0] of w3
  // w2: [31:0] ip mask / {ethertype, mac[47:32]}
  // w3: [7:0] tcp flag value [27:8] action (pm[1:0] ranking[2:0] ...)
  //     action: [9:8] priority_override_mode [12:10] ranking_value [13] remark_enable
  //     [16:14] remark_level [18:17] fwd_merge_kind [25:19] action map
  //     [26] time_unit_sel [27] counter_algorithm
  // w3 hi: unused; process word in separate array
  // count value = w3[18:8] (11 bits: pm, ranking, remark_enable, remark_level, merge)
  // process: [15:0] match_group_bits [19:16] entry_rank [23:20] action index
  logic [31:0] tbl [ACLRM_ENTRIES][4];
  logic [23:0] proc_w [ACLRM_ENTRIES];

  typedef struct packed {
    logic [ACLRM_ENTRIES-1:0]       evt;
    logic [ACLRM_ENTRIES-1:0]       mask;
    logic                           enable;
    logic [ACLRM_ENTRIES-1:0][10:0] cnt;
    logic [ACLRM_ENTRIES-1:0][19:0] tick;
    logic [ACLRM_ENTRIES-1:0]       armed;
    logic                           ack;
    logic [31:0]                    rdat;
    aclrm_res_s                     res;
    logic                           res_v;
  } aclrm_state_s;

  aclrm_state_s st, next_st;

  logic                       wb_req;
  logic [ACLRM_ENTRIES-1:0]   hit;
  logic [ACLRM_ENTRIES-1:0]   is_cnt;
  logic [ACLRM_ENTRIES-1:0]   grp_hit;
  logic                       wb_wr;
  logic [31:0]                tbl_rd;

  assign wb_req = WB_CYC_I && WB_STB_I && !st.ack;
  // writes land at the edge where the master sees ack
  assign wb_wr  = WB_CYC_I && WB_STB_I && WB_WE_I && st.ack;
  assign tbl_rd = tbl[WB_ADR_I[5:2]][WB_ADR_I[1:0]];

  // ----------------------------------------
  // per-entry matching
  // ----------------------------------------
  always_comb begin
    for (int e = 0; e < ACLRM_ENTRIES; e++) begin
      logic [1:0]  md;
      logic [1:0]  cs;
      logic        sd;
      logic        eq;
      logic [1:0]  pc;
      logic [47:0] mac;
      logic [31:0] a;
      logic [31:0] m;
      logic [15:0] port;
      logic [15:0] lo;
      logic [15:0] hi;
      logic        raw;
      logic        prt;
      logic        flg;
      md   = tbl[e][0][1:0];
      cs   = tbl[e][0][3:2];
      sd   = tbl[e][0][4];
      eq   = tbl[e][0][5];
      pc   = tbl[e][0][7:6];
      a    = tbl[e][1];
      m    = tbl[e][2];
      lo   = a[15:0];
      hi   = a[31:16];
      mac  = sd ? PKT_HDR.mac_src : PKT_HDR.mac_dst;
      port = sd ? PKT_HDR.l4_src : PKT_HDR.l4_dst;
      raw  = 1'b0;
      prt  = 1'b1;
      // tcp flag check, ignored bits skipped
      flg  = !tbl[e][0][16] ||
             (((PKT_HDR.tcp_flags ^ tbl[e][3][7:0]) & ~tbl[e][0][24:17]) == 8'h00);
      is_cnt[e] = (md == ACLRM_MD_L2) && (cs == ACLRM_SEL_0);
      unique case (pc)
        ACLRM_SEL_0: prt = 1'b1;
        ACLRM_SEL_1: prt = (port == lo) || (port == hi);
        ACLRM_SEL_2: prt = (port >= lo) && (port <= hi);
        ACLRM_SEL_3: prt = (port < lo) || (port > hi);
      endcase
      unique case (md)
        ACLRM_MD_OFF: raw = 1'b0;
        ACLRM_MD_L2: begin
          unique case (cs)
            ACLRM_SEL_1: raw = (mac == {m[15:0], a});
            ACLRM_SEL_2: raw = (PKT_HDR.ethertype == m[31:16]);
            default:     raw = (mac == {m[15:0], a}) && (PKT_HDR.ethertype == m[31:16]);
          endcase
        end
        ACLRM_MD_L3: begin
          unique case (cs)
            ACLRM_SEL_1: raw = PKT_HDR.is_ipv4 &&
              ((((sd ? PKT_HDR.ip_src : PKT_HDR.ip_dst) ^ a) & ~m) == 32'h0000_0000);
            ACLRM_SEL_2: raw = PKT_HDR.is_ipv4 && (PKT_HDR.ip_src == a) && (PKT_HDR.ip_dst == m);
            default:     raw = 1'b0;
          endcase
        end
        ACLRM_MD_L4: begin
          unique case (cs)
            ACLRM_SEL_0: raw = PKT_HDR.is_ipv4 && (PKT_HDR.ip_proto == tbl[e][0][15:8]);
            ACLRM_SEL_1: raw = PKT_HDR.is_tcp && prt && flg;
            ACLRM_SEL_2: raw = PKT_HDR.is_udp && prt;
            ACLRM_SEL_3: raw = PKT_HDR.is_tcp && (PKT_HDR.tcp_seq == {hi, lo}) && flg;
          endcase
        end
      endcase
      // polarity applies only to enabled non-reserved compares
      if (md == ACLRM_MD_OFF || (md == ACLRM_MD_L3 && (cs == ACLRM_SEL_0 || cs == ACLRM_SEL_3))) begin
        hit[e] = 1'b0;
      end else begin
        hit[e] = eq ? raw : !raw;
      end
    end
  end

  // ----------------------------------------
  // rule group hits
  // ----------------------------------------
  always_comb begin
    for (int g = 0; g < ACLRM_ENTRIES; g++) begin
      grp_hit[g] = (proc_w[g][15:0] != 16'h0000) &&
                   ((proc_w[g][15:0] & ~(hit & ~is_cnt)) == 16'h0000);
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic        found;
    logic [3:0]  best_rank;
    logic [3:0]  act;
    logic [31:0] aw;
    logic [2:0]  rv;
    logic [ACLRM_ENTRIES-1:0] fire;
    next_st   = st;
    found     = 1'b0;
    best_rank = 4'hf;
    act       = 4'h0;
    fire      = '0;
    aw        = 32'h0000_0000;
    rv        = 3'h0;
    for (int g = 0; g < ACLRM_ENTRIES; g++) begin
      if (grp_hit[g] && (!found || proc_w[g][19:16] < best_rank)) begin
        found     = 1'b1;
        best_rank = proc_w[g][19:16];
        act       = proc_w[g][23:20];
      end
    end
    aw = tbl[act][3];
    rv = aw[12:10];
    // result registered one cycle after the header, ahead of forwarding
    next_st.res_v           = PKT_VALID && st.enable;
    next_st.res.hit         = found;
    next_st.res.prio        = PKT_HDR.qos_prio;
    next_st.res.pcp         = PKT_HDR.pcp;
    next_st.res.pcp_changed = 1'b0;
    next_st.res.fwd_map     = PKT_HDR.lut_map;
    if (found) begin
      unique case (aw[9:8])
        ACLRM_SEL_0: next_st.res.prio = PKT_HDR.qos_prio;
        ACLRM_SEL_1: next_st.res.prio = (rv > PKT_HDR.qos_prio) ? rv : PKT_HDR.qos_prio;
        ACLRM_SEL_2: next_st.res.prio = (rv < PKT_HDR.qos_prio) ? rv : PKT_HDR.qos_prio;
        ACLRM_SEL_3: next_st.res.prio = rv;
      endcase
      if (aw[13]) begin
        next_st.res.pcp         = aw[16:14];
        next_st.res.pcp_changed = 1'b1;
      end
      unique case (aw[18:17])
        ACLRM_SEL_0: next_st.res.fwd_map = PKT_HDR.lut_map;
        ACLRM_SEL_1: next_st.res.fwd_map = PKT_HDR.lut_map | aw[25:19];
        ACLRM_SEL_2: next_st.res.fwd_map = PKT_HDR.lut_map & aw[25:19];
        ACLRM_SEL_3: next_st.res.fwd_map = aw[25:19];
      endcase
    end

    // count-mode entries, same index action word
    for (int e = 0; e < ACLRM_ENTRIES; e++) begin
      logic [10:0] cv;
      logic        pkt;
      logic [19:0] unit;
      cv   = tbl[e][3][18:8];
      pkt  = PKT_VALID && st.enable && hit[e];
      unit = tbl[e][3][26] ? 20'(US_CYCLES * US_PER_MS) : 20'(US_CYCLES);
      if (!is_cnt[e]) begin
        next_st.cnt[e]   = 11'h000;
        next_st.tick[e]  = 20'h00000;
        next_st.armed[e] = 1'b0;
      end else if (tbl[e][3][27]) begin
        next_st.tick[e] = 20'h00000;
        if (pkt) begin
          if (st.cnt[e] + 11'h001 >= cv) begin
            fire[e]        = 1'b1;
            next_st.cnt[e] = 11'h000;
          end else begin
            next_st.cnt[e] = st.cnt[e] + 11'h001;
          end
        end
      end else begin
        if (pkt) begin
          next_st.cnt[e]   = cv;
          next_st.tick[e]  = 20'h00000;
          next_st.armed[e] = 1'b1;
        end else if (st.armed[e]) begin
          if (st.tick[e] + 20'h00001 >= unit) begin
            next_st.tick[e] = 20'h00000;
            if (st.cnt[e] <= 11'h001) begin
              fire[e]          = 1'b1;
              next_st.cnt[e]   = 11'h000;
              next_st.armed[e] = 1'b0;
            end else begin
              next_st.cnt[e] = st.cnt[e] - 11'h001;
            end
          end else begin
            next_st.tick[e] = st.tick[e] + 20'h00001;
          end
        end
      end
    end

    // wishbone slave, registered ack one cycle after strobe
    next_st.ack = wb_req;
    if (wb_req && !WB_WE_I) begin
      unique case (WB_ADR_I)
        ACLRM_OFF_STATUS: next_st.rdat = {16'h0000, st.evt};
        ACLRM_OFF_MASK:   next_st.rdat = {16'h0000, st.mask};
        ACLRM_OFF_CTRL:   next_st.rdat = {31'h0, st.enable};
        ACLRM_OFF_ID:     next_st.rdat = ACLRM_ID_VALUE;
        default:          next_st.rdat = (WB_ADR_I < 8'h40) ? tbl_rd :
                                         (WB_ADR_I < 8'h80 && WB_ADR_I >= 8'h40) ?
                                         {8'h00, proc_w[WB_ADR_I[5:2]]} : 32'h0000_0000;
      endcase
    end
    // sticky events, set wins over clear
    next_st.evt = st.evt;
    if (wb_wr && WB_ADR_I == ACLRM_OFF_STATUS) begin
      if (WB_SEL_I[0]) next_st.evt[7:0]  = st.evt[7:0] & ~WB_DAT_I[7:0];
      if (WB_SEL_I[1]) next_st.evt[15:8] = st.evt[15:8] & ~WB_DAT_I[15:8];
    end
    next_st.evt = next_st.evt | fire;
    if (wb_wr && WB_ADR_I == ACLRM_OFF_MASK) begin
      if (WB_SEL_I[0]) next_st.mask[7:0]  = WB_DAT_I[7:0];
      if (WB_SEL_I[1]) next_st.mask[15:8] = WB_DAT_I[15:8];
    end
    if (wb_wr && WB_ADR_I == ACLRM_OFF_CTRL && WB_SEL_I[0]) begin
      next_st.enable = WB_DAT_I[0];
    end
  end

  // ----------------------------------------
  // table storage, words at {entry, word}
  // ----------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (wb_wr && WB_ADR_I < 8'h40) begin
      for (int b = 0; b < 4; b++) begin
        if (WB_SEL_I[b]) tbl[WB_ADR_I[5:2]][WB_ADR_I[1:0]][b*8 +: 8] <= WB_DAT_I[b*8 +: 8];
      end
    end
    if (wb_wr && WB_ADR_I >= 8'h40 && WB_ADR_I < 8'h80) begin
      for (int b = 0; b < 3; b++) begin
        if (WB_SEL_I[b]) proc_w[WB_ADR_I[5:2]][b*8 +: 8] <= WB_DAT_I[b*8 +: 8];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign WB_ACK_O  = st.ack;
  assign WB_DAT_O  = st.rdat;
  assign RES       = st.res;
  assign RES_VALID = st.res_v;
  assign EVENT_OUT = |(st.evt & st.mask);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_evt_sticky;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      (|st.evt) && !(wb_wr && WB_ADR_I == ACLRM_OFF_STATUS) |=> (st.evt & $past(st.evt)) == $past(st.evt);
  endproperty
  a_evt_sticky: assert property (p_evt_sticky) else $error("event bit lost without clear");

  property p_res_follows;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      PKT_VALID && st.enable |=> RES_VALID;
  endproperty
  a_res_follows: assert property (p_res_follows) else $error("result not one cycle after packet");

  property p_no_hit_keeps_map;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      PKT_VALID && st.enable && grp_hit == '0 |=> RES.fwd_map == $past(PKT_HDR.lut_map) && !RES.hit;
  endproperty
  a_no_hit_keeps_map: assert property (p_no_hit_keeps_map) else $error("map changed without match");

  property p_no_hit_prio;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      PKT_VALID && grp_hit == '0 |=> RES.prio == $past(PKT_HDR.qos_prio) && !RES.pcp_changed;
  endproperty
  a_no_hit_prio: assert property (p_no_hit_prio) else $error("priority changed without match");

  property p_ack_one;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

  property p_off_no_hit;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      tbl[0][0][1:0] == ACLRM_MD_OFF |-> !hit[0];
  endproperty
  a_off_no_hit: assert property (p_off_no_hit) else $error("disabled entry matched");

  property p_empty_group;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      proc_w[0][15:0] == 16'h0000 |-> !grp_hit[0];
  endproperty
  a_empty_group: assert property (p_empty_group) else $error("empty group matched");

  property p_cnt_range;
    @(posedge SYS_CLK) disable iff (!ARST_N)
      is_cnt[2] && !tbl[2][3][27] |-> st.cnt[2] <= tbl[2][3][18:8] || !st.armed[2];
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("down counter above load");

endmodule : aclrm_top

// *** core/aclrm_pkg.sv ***
// package for the per-port acl rule match and action block
package aclrm_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ACLRM_OFF_TBL_BASE  = 8'h00; // entry e, word w at {e[3:0], w[1:0]}
  localparam logic [7:0] ACLRM_OFF_STATUS    = 8'h80;
  localparam logic [7:0] ACLRM_OFF_MASK      = 8'h84;
  localparam logic [7:0] ACLRM_OFF_CTRL      = 8'h88;
  localparam logic [7:0] ACLRM_OFF_ID        = 8'h8c;
  localparam logic [31:0] ACLRM_ID_VALUE     = 32'h0a5c_0001; // arbitrary value

  // ----------------------------------------
  // field encodings
  // ----------------------------------------
  localparam logic [1:0] ACLRM_MD_OFF = 2'h0;
  localparam logic [1:0] ACLRM_MD_L2  = 2'h1;
  localparam logic [1:0] ACLRM_MD_L3  = 2'h2;
  localparam logic [1:0] ACLRM_MD_L4  = 2'h3;
  localparam logic [1:0] ACLRM_SEL_0  = 2'h0;
  localparam logic [1:0] ACLRM_SEL_1  = 2'h1;
  localparam logic [1:0] ACLRM_SEL_2  = 2'h2;
  localparam logic [1:0] ACLRM_SEL_3  = 2'h3;
  localparam int         ACLRM_ENTRIES = 16;
  localparam int         ACLRM_PORTS   = 7;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ        = 100;
  localparam int US_NS          = 1000;
  localparam int US_CYCLES      = US_NS * CLK_MHZ / 1000;
  localparam int MS_PER_US      = 1000;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [47:0] mac_dst;
    logic [47:0] mac_src;
    logic [15:0] ethertype;
    logic        is_ipv4;
    logic [31:0] ip_src;
    logic [31:0] ip_dst;
    logic [7:0]  ip_proto;
    logic        is_tcp;
    logic        is_udp;
    logic [15:0] l4_src;
    logic [15:0] l4_dst;
    logic [31:0] tcp_seq;
    logic [7:0]  tcp_flags;
    logic [2:0]  qos_prio;
    logic [2:0]  pcp;
    logic [ACLRM_PORTS-1:0] lut_map;
  } aclrm_hdr_s;

  typedef struct packed {
    logic [2:0]  prio;
    logic [2:0]  pcp;
    logic        pcp_changed;
    logic        hit;
    logic [ACLRM_PORTS-1:0] fwd_map;
  } aclrm_res_s;

endpackage : aclrm_pkg

// *** testbench/aclrm_fwd_model.sv ***
// forwarding-side partner: header source and result sink
module aclrm_fwd_model
  import aclrm_pkg::*;
(
  input  wire logic       clk,
  input  wire aclrm_res_s res,
  input  wire logic       res_valid,
  output logic            pkt_valid,
  output aclrm_hdr_s      pkt_hdr
);
  timeunit 1ns;
  timeprecision 1ps;
  aclrm_res_s got;
  int         n_res;
  initial begin
    pkt_valid = 1'b0;
    pkt_hdr   = '0;
    n_res     = 0;
    got       = '0;
  end
  always @(posedge clk) begin
    if (res_valid === 1'b1) begin
      got   <= res;
      n_res <= n_res + 1;
    end
  end
  // one header per call; released header is inverted
  task automatic send(input aclrm_hdr_s h);
    @(posedge clk);
    pkt_valid <= 1'b1;
    pkt_hdr   <= h;
    @(posedge clk);
    pkt_valid <= 1'b0;
    pkt_hdr   <= ~h;
    @(posedge clk);
    #1;
  endtask : send
endmodule : aclrm_fwd_model

// *** testbench/tb_top.sv ***
// self-checking bench for the acl rule match block
module tb_top;
  import aclrm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        sys_clk, arst_n, wb_cyc, wb_stb, wb_we, wb_ack, pkt_valid, res_valid, event_out;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat, wb_dat_o, a1, a2;
  aclrm_hdr_s  pkt_hdr, h0, h;
  aclrm_res_s  res;
  int          bad_count, n_compared, cycles, n0;
  logic [1:0]  pcs [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  logic [15:0] dsts [6] = '{16'h0064, 16'h004b, 16'h0032, 16'h0065, 16'h0031, 16'h004b};
  logic        hits [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  aclrm_top #(.US_PER_MS(2)) u_aclrm_top (.SYS_CLK(sys_clk), .ARST_N(arst_n), .WB_CYC_I(wb_cyc),
    .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat),
    .WB_DAT_O(wb_dat_o), .WB_ACK_O(wb_ack), .PKT_VALID(pkt_valid), .PKT_HDR(pkt_hdr), .RES(res),
    .RES_VALID(res_valid), .EVENT_OUT(event_out));
  aclrm_fwd_model u_aclrm_fwd_model (.clk(sys_clk), .res(res), .res_valid(res_valid),
    .pkt_valid(pkt_valid), .pkt_hdr(pkt_hdr));
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count = bad_count + 1;
      results();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_res(input aclrm_res_s e, input aclrm_res_s g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD res expected %h seen %h", e, g);
    end
  endtask : chk_res
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} <= {2'h3, we, adr, 4'hf, d};
    do @(posedge sys_clk); while (wb_ack !== 1'b1);
    q = wb_dat_o;
    {wb_cyc, wb_stb} <= 2'h0;
  endtask : wb
  task automatic w(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, adr, d, q);
  endtask : w
  task automatic r(input logic [7:0] adr, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, adr, 32'h0, q);
    chk($sformatf("reg %h", adr), e, q);
  endtask : r
  task automatic ent(input logic [3:0] e, input logic [31:0] m0, m1, m2, m3);
    w({2'h0, e, 2'h0}, m0);
    w({2'h0, e, 2'h1}, m1);
    w({2'h0, e, 2'h2}, m2);
    w({2'h0, e, 2'h3}, m3);
  endtask : ent
  task automatic grp(input logic [3:0] g, input logic [15:0] bits, input logic [3:0] rank, ai);
    w({2'h1, g, 2'h0}, {8'h0, ai, rank, bits});
  endtask : grp
  function automatic logic [31:0] act(input logic [1:0] m, input logic [2:0] rv, input logic [6:0] map);
    return {6'h0, map, m, 3'h6, m[0], rv, m, 8'h0};
  endfunction : act
  function automatic aclrm_res_s exp_res(input logic hit, input aclrm_hdr_s x, input logic [31:0] a);
    aclrm_res_s e;
    e = '{prio: x.qos_prio, pcp: x.pcp, pcp_changed: 1'b0, hit: hit, fwd_map: x.lut_map};
    if (hit) begin
      if (a[9:8] == 2'h3 || (a[9:8] == 2'h1 && a[12:10] > x.qos_prio) ||
          (a[9:8] == 2'h2 && a[12:10] < x.qos_prio)) e.prio = a[12:10];
      if (a[13]) e.pcp = a[16:14];
      e.pcp_changed = a[13];
      if (a[18:17] == 2'h1) e.fwd_map = x.lut_map | a[25:19];
      if (a[18:17] == 2'h2) e.fwd_map = x.lut_map & a[25:19];
      if (a[18:17] == 2'h3) e.fwd_map = a[25:19];
    end
    return e;
  endfunction : exp_res
  task automatic pk(input aclrm_hdr_s x, input logic hit, input logic [31:0] a);
    u_aclrm_fwd_model.send(x);
    chk_res(exp_res(hit, x, a), u_aclrm_fwd_model.got);
  endtask : pk
  task automatic evc(input int n, input logic e);
    repeat (n) @(posedge sys_clk);
    #1;
    chk("event_out", {31'h0, e}, {31'h0, event_out});
  endtask : evc
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {sys_clk, arst_n, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
    {bad_count, n_compared, cycles} = '0;
    h0 = '{mac_dst: 48'h0200_0000_0011, mac_src: 48'h0200_0000_0022, ethertype: 16'h0800, is_ipv4: 1'b1,
      ip_src: 32'h0a00_01ab, ip_dst: 32'hc0a8_0005, ip_proto: 8'h06, is_tcp: 1'b1, is_udp: 1'b0,
      l4_src: 16'h04d2, l4_dst: 16'h004b, tcp_seq: 32'h1234_5678, tcp_flags: 8'h12, qos_prio: 3'h2,
      pcp: 3'h1, lut_map: 7'h0f};
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    r(ACLRM_OFF_ID, ACLRM_ID_VALUE);
    r(ACLRM_OFF_STATUS, 32'h0);
    w(8'h90, 32'hffff_ffff);
    r(8'h90, 32'h0);
    for (int e = 0; e < 16; e++) begin
      ent(4'(e), 32'h0, 32'h0, 32'h0, 32'h0);
      grp(4'(e), 16'h0, 4'h0, 4'h0);
    end
    w(ACLRM_OFF_CTRL, 32'h1);
    r(ACLRM_OFF_CTRL, 32'h1);
    a1 = act(2'h3, 3'h4, 7'h55);
    ent(4'h0, 32'h25, 32'h0000_0011, 32'h0800_0200, 32'h0);
    grp(4'h0, 16'h0001, 4'h3, 4'h1);
    for (int m = 0; m < 8; m++) begin
      w(8'h07, act(2'(m), 3'h4, 7'h55));
      h = h0;
      h.qos_prio = m[2] ? 3'h6 : 3'h1;
      pk(h, 1'b1, act(2'(m), 3'h4, 7'h55));
    end
    h = h0;
    h.mac_dst = 48'h0200_0000_0012;
    pk(h, 1'b0, a1);
    ent(4'h0, 32'h29, 32'h0, 32'h0800_0000, 32'h0);
    pk(h, 1'b1, a1);
    h.ethertype = 16'h86dd;
    pk(h, 1'b0, a1);
    ent(4'h0, 32'h3d, 32'h0000_0022, 32'h0800_0200, 32'h0);
    pk(h0, 1'b1, a1);
    ent(4'h0, 32'h36, 32'h0a00_0100, 32'h0000_00ff, 32'h0);
    pk(h0, 1'b1, a1);
    h = h0;
    h.ip_src = 32'h0a00_02ab;
    pk(h, 1'b0, a1);
    ent(4'h0, 32'h16, 32'h0a00_0100, 32'h0000_00ff, 32'h0);
    pk(h0, 1'b0, a1);
    pk(h, 1'b1, a1);
    ent(4'h0, 32'h2a, 32'h0a00_01ab, 32'hc0a8_0005, 32'h0);
    pk(h0, 1'b1, a1);
    h = h0;
    h.ip_dst = 32'hc0a8_0006;
    pk(h, 1'b0, a1);
    ent(4'h0, 32'h22, 32'h0a00_01ab, 32'hc0a8_0005, 32'h0);
    pk(h0, 1'b0, a1);
    ent(4'h0, 32'h0623, 32'h0, 32'h0, 32'h0);
    pk(h0, 1'b1, a1);
    ent(4'h0, 32'h1123, 32'h0, 32'h0, 32'h0);
    pk(h0, 1'b0, a1);
    for (int i = 0; i < 6; i++) begin
      ent(4'h0, {24'h0, pcs[i], 6'h27}, 32'h0064_0032, 32'h0, 32'h0);
      h = h0;
      h.l4_dst = dsts[i];
      pk(h, hits[i], a1);
    end
    ent(4'h0, 32'h0001_00a7, 32'h0064_0032, 32'h0, 32'h10);
    pk(h0, 1'b0, a1);
    ent(4'h0, 32'h0005_00a7, 32'h0064_0032, 32'h0, 32'h10);
    pk(h0, 1'b1, a1);
    ent(4'h0, 32'hab, 32'h0064_0032, 32'h0, 32'h0);
    h = h0;
    {h.is_tcp, h.is_udp} = 2'h1;
    pk(h, 1'b1, a1);
    ent(4'h0, 32'h2f, 32'h1234_5678, 32'h0, 32'h0);
    pk(h0, 1'b1, a1);
    h = h0;
    h.tcp_seq = 32'h1234_5679;
    pk(h, 1'b0, a1);
    ent(4'h0, 32'h0623, 32'h0, 32'h0, 32'h0);
    a2 = act(2'h1, 3'h7, 7'h30);
    w(8'h0f, a2);
    grp(4'h1, 16'h0003, 4'h2, 4'h3);
    pk(h0, 1'b1, a1);
    w(8'h04, 32'h0623);
    pk(h0, 1'b1, a2);
    grp(4'h1, 16'h0003, 4'h5, 4'h3);
    pk(h0, 1'b1, a1);
    w(ACLRM_OFF_CTRL, 32'h0);
    n0 = u_aclrm_fwd_model.n_res;
    u_aclrm_fwd_model.send(h0);
    chk("results while off", n0, u_aclrm_fwd_model.n_res);
    w(ACLRM_OFF_CTRL, 32'h1);
    grp(4'h0, 16'h0, 4'h0, 4'h0);
    grp(4'h1, 16'h0, 4'h0, 4'h0);
    ent(4'h2, 32'h21, 32'h0000_0011, 32'h0800_0200, 32'h0800_0300);
    w(ACLRM_OFF_MASK, 32'h0004);
    repeat (2) u_aclrm_fwd_model.send(h0);
    evc(2, 1'b0);
    u_aclrm_fwd_model.send(h0);
    evc(2, 1'b1);
    r(ACLRM_OFF_STATUS, 32'h0004);
    w(ACLRM_OFF_STATUS, 32'h0004);
    evc(1, 1'b0);
    w(ACLRM_OFF_MASK, 32'h0);
    repeat (3) u_aclrm_fwd_model.send(h0);
    evc(2, 1'b0);
    r(ACLRM_OFF_STATUS, 32'h0004);
    w(ACLRM_OFF_MASK, 32'h0004);
    w(8'h0b, 32'h0000_0200);
    w(ACLRM_OFF_STATUS, 32'h0004);
    u_aclrm_fwd_model.send(h0);
    evc(90, 1'b0);
    evc(160, 1'b1);
    w(8'h0b, 32'h0400_0200);
    w(ACLRM_OFF_STATUS, 32'h0004);
    u_aclrm_fwd_model.send(h0);
    evc(190, 1'b0);
    evc(260, 1'b1);
    results();
  end
endmodule : tb_top
